// ---- logic/gsq_sequencer.sv ----
// Implementation choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
module gsq_sequencer #(
  parameter int unsigned STEPS       = gsq_pkg::MAX_STEPS,
  parameter int unsigned TICK_CYCLES = gsq_pkg::TICK_CYC_DFLT,
  parameter int unsigned LP_TICKS    = gsq_pkg::LP_TICKS_DFLT,
  parameter bit          PICKUP      = 1'b1,
  parameter logic [15:0] FIRE_SPEED  = 16'd500
) (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output var  logic [31:0]                    prdata,
  output var  logic                           pready,
  output var  logic                           pslverr,
  // measurements and internal requests
  input  wire gsq_pkg::gsq_meas_s             meas,
  input  wire logic                           sched_req,
  input  wire logic                           telem_req,
  // asynchronous pins
  input  wire logic [gsq_pkg::NPIN-1:0]       pins,
  // plant outputs
  output var  logic [gsq_pkg::MAX_STEPS-1:0]  dummy_out,
  output var  logic [gsq_pkg::MAX_STEPS-1:0]  shed_out,
  output var  logic                           fuel_out,
  output var  logic                           crank_out,
  output var  logic                           gen_close,
  output var  logic                           ecu_power,
  output var  logic                           low_power,
  output var  logic                           fail_to_stop,
  output var  logic                           alarm_reset,
  output var  logic                           cfg_unlocked
);
  if (STEPS < 1 || STEPS > gsq_pkg::MAX_STEPS || TICK_CYCLES < 1 || TICK_CYCLES > 1000000
      || LP_TICKS < 1 || LP_TICKS > 1000000) begin : g_param_chk
    $error("gsq_sequencer: parameter out of range");
  end

  gsq_pkg::gsq_state_s s_ff;
  gsq_pkg::gsq_state_s nxt_s;

  // thermometer mask of a configured step count, clipped to the fitted steps
  function automatic logic [gsq_pkg::MAX_STEPS-1:0] step_mask(input logic [2:0] n);
    logic [2:0] k;
    k = (32'(n) > STEPS) ? 3'(STEPS) : n;
    return 5'((6'h01 << k) - 6'h01);
  endfunction

  // saturating tick advance
  function automatic logic [15:0] adv(input logic [15:0] c, input logic t);
    return (c == 16'hffff) ? c : c + {15'h0000, t};
  endfunction

  logic [gsq_pkg::NPIN-1:0] p;
  logic [3:0]  btn_rise;
  logic        tick;
  logic        at_rest;
  logic        any_req;
  logic        start_due;
  logic        cfg_ok;
  logic        acc;
  logic        cfg_reg;
  logic        mapped;
  logic        mode_wr;
  logic        stop_req;
  logic        auto_req;
  logic        on_load;
  logic [31:0] rd;

  // decode of pins, requests, and apb addresses
  always_comb begin
    p         = s_ff.sync2;
    btn_rise  = p[3:0] & ~s_ff.pin_q[3:0];
    tick      = (s_ff.pre == 20'(TICK_CYCLES - 1));
    at_rest   = meas.speed == 16'h0000 && meas.freq == 16'h0000
                && (!PICKUP || p[gsq_pkg::P_OIL]);
    any_req   = s_ff.auto_mode && (p[gsq_pkg::P_AUX] || p[gsq_pkg::P_LINK]
                || sched_req || telem_req);
    start_due = (p[gsq_pkg::P_AUX]  && s_ff.start_cnt >= s_ff.cfg.start_a[15:0])
             || (p[gsq_pkg::P_LINK] && s_ff.start_cnt >= s_ff.cfg.start_a[31:16])
             || (sched_req          && s_ff.start_cnt >= s_ff.cfg.start_b[15:0])
             || (telem_req          && s_ff.start_cnt >= s_ff.cfg.start_b[31:16]);
    cfg_ok    = !s_ff.auto_mode && s_ff.seq == gsq_pkg::SEQ_IDLE && at_rest;
    acc       = psel && penable;
    cfg_reg   = paddr == gsq_pkg::OFS_CTRL || (paddr >= gsq_pkg::OFS_DUMMY_LVL
                && paddr <= gsq_pkg::OFS_START_B && paddr[1:0] == 2'b00);
    mapped    = cfg_reg || paddr == gsq_pkg::OFS_MODE || paddr == gsq_pkg::OFS_STATUS;
    mode_wr   = acc && pwrite && paddr == gsq_pkg::OFS_MODE;
    stop_req  = (btn_rise[gsq_pkg::P_STOP] || (mode_wr && pwdata[0]))
                && !p[gsq_pkg::P_LOCK];
    auto_req  = (btn_rise[gsq_pkg::P_AUTO] || (mode_wr && pwdata[1]))
                && !p[gsq_pkg::P_LOCK] && !stop_req;
    on_load   = s_ff.seq == gsq_pkg::SEQ_ONLOAD && p[gsq_pkg::P_BRK];
    case (paddr)
      gsq_pkg::OFS_CTRL:      rd = {17'h00000, s_ff.cfg.shed_start_n, 1'b0,
                                    s_ff.cfg.shed_n, 1'b0, s_ff.cfg.dummy_n, 1'b0,
                                    s_ff.cfg.lp_en, s_ff.cfg.shed_en, s_ff.cfg.dummy_en};
      gsq_pkg::OFS_MODE:      rd = {31'h00000000, s_ff.auto_mode};
      gsq_pkg::OFS_DUMMY_LVL: rd = s_ff.cfg.dummy_lvl;
      gsq_pkg::OFS_SHED_LVL:  rd = s_ff.cfg.shed_lvl;
      gsq_pkg::OFS_DUMMY_DLY: rd = s_ff.cfg.dummy_dly;
      gsq_pkg::OFS_SHED_DLY:  rd = s_ff.cfg.shed_dly;
      gsq_pkg::OFS_STOP_DLY:  rd = s_ff.cfg.stop_dly;
      gsq_pkg::OFS_START_A:   rd = s_ff.cfg.start_a;
      gsq_pkg::OFS_START_B:   rd = s_ff.cfg.start_b;
      gsq_pkg::OFS_STATUS:    rd = {7'h00, s_ff.shed, s_ff.dummy, 4'h0, s_ff.seq,
                                    cfg_ok, at_rest, s_ff.fts_alarm, s_ff.low_power,
                                    s_ff.ecu, s_ff.close, s_ff.crank, s_ff.fuel};
      default:                rd = 32'h00000000;
    endcase
  end

  // zero-wait slave; refused config writes and unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = acc && (!mapped || (pwrite && cfg_reg && !cfg_ok)
                   || (pwrite && paddr == gsq_pkg::OFS_STATUS));
  assign prdata  = s_ff.prdata;

  // next-state logic
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.sync1     = pins;
    nxt_s.sync2     = s_ff.sync1;
    nxt_s.pin_q     = s_ff.sync2;
    nxt_s.pre       = tick ? 20'h00000 : s_ff.pre + 20'h00001;
    nxt_s.alarm_clr = 1'b0;
    if (psel && !penable) begin
      nxt_s.prdata = rd;
    end
    // configuration writes, stopped engine only
    if (acc && pwrite && cfg_reg && cfg_ok) begin
      case (paddr)
        gsq_pkg::OFS_CTRL: begin
          nxt_s.cfg.dummy_en     = pwdata[0];
          nxt_s.cfg.shed_en      = pwdata[1];
          nxt_s.cfg.lp_en        = pwdata[2];
          nxt_s.cfg.dummy_n      = pwdata[6:4];
          nxt_s.cfg.shed_n       = pwdata[10:8];
          nxt_s.cfg.shed_start_n = pwdata[14:12];
        end
        gsq_pkg::OFS_DUMMY_LVL: nxt_s.cfg.dummy_lvl = pwdata;
        gsq_pkg::OFS_SHED_LVL:  nxt_s.cfg.shed_lvl  = pwdata;
        gsq_pkg::OFS_DUMMY_DLY: nxt_s.cfg.dummy_dly = pwdata;
        gsq_pkg::OFS_SHED_DLY:  nxt_s.cfg.shed_dly  = pwdata;
        gsq_pkg::OFS_STOP_DLY:  nxt_s.cfg.stop_dly  = pwdata;
        gsq_pkg::OFS_START_A:   nxt_s.cfg.start_a   = pwdata;
        gsq_pkg::OFS_START_B:   nxt_s.cfg.start_b   = pwdata;
        default:                nxt_s.cfg = s_ff.cfg;
      endcase
    end
    // mode changes
    if (stop_req && s_ff.auto_mode) begin
      nxt_s.auto_mode = 1'b0;
      nxt_s.alarm_clr = 1'b1;
      if (at_rest) begin
        nxt_s.fts_alarm = 1'b0;
      end
    end else if (auto_req) begin
      nxt_s.auto_mode = 1'b1;
    end
    // start and stop sequence
    case (s_ff.seq)
      gsq_pkg::SEQ_IDLE: begin
        nxt_s.start_cnt = 16'h0000;
        if (any_req) begin
          nxt_s.seq = gsq_pkg::SEQ_DELAY;
        end
      end
      gsq_pkg::SEQ_DELAY: begin
        if (!any_req) begin
          nxt_s.seq = gsq_pkg::SEQ_IDLE;
        end else if (start_due) begin
          nxt_s.seq = gsq_pkg::SEQ_CRANK;
        end else begin
          nxt_s.start_cnt = adv(s_ff.start_cnt, tick);
        end
      end
      gsq_pkg::SEQ_CRANK: begin
        if (meas.speed >= FIRE_SPEED) begin
          nxt_s.seq = gsq_pkg::SEQ_PRELOAD; // shed a cycle before close
          if (s_ff.cfg.shed_en) begin
            nxt_s.shed = step_mask(s_ff.cfg.shed_start_n);
          end
        end
      end
      gsq_pkg::SEQ_PRELOAD: begin
        nxt_s.seq = gsq_pkg::SEQ_ONLOAD;
      end
      gsq_pkg::SEQ_ONLOAD: begin
        if (!any_req) begin
          nxt_s.seq = gsq_pkg::SEQ_STOPPING;
        end
      end
      gsq_pkg::SEQ_STOPPING: begin
        nxt_s.stop_cnt = adv(s_ff.stop_cnt, tick);
        if (at_rest) begin
          nxt_s.seq = gsq_pkg::SEQ_IDLE;
        end else if (s_ff.stop_cnt >= s_ff.cfg.stop_dly[15:0]) begin
          nxt_s.fts_alarm = 1'b1;
        end
      end
      default: nxt_s.seq = gsq_pkg::SEQ_IDLE;
    endcase
    // stop mode takes a running set straight off load and stops it
    if (!nxt_s.auto_mode && nxt_s.seq != gsq_pkg::SEQ_IDLE) begin
      nxt_s.seq = gsq_pkg::SEQ_STOPPING;
    end
    if (nxt_s.seq == gsq_pkg::SEQ_STOPPING && s_ff.seq != gsq_pkg::SEQ_STOPPING) begin
      nxt_s.stop_cnt = 16'h0000;
      nxt_s.shed     = '0;
    end
    // dummy load stepping
    nxt_s.d_trip_cnt = 16'h0000;
    nxt_s.d_ret_cnt  = 16'h0000;
    if (on_load && s_ff.cfg.dummy_en) begin
      if (meas.load < s_ff.cfg.dummy_lvl[15:0]
          && s_ff.dummy != step_mask(s_ff.cfg.dummy_n)) begin
        if (s_ff.d_trip_cnt >= s_ff.cfg.dummy_dly[15:0]) begin
          nxt_s.dummy = {s_ff.dummy[gsq_pkg::MAX_STEPS-2:0], 1'b1};
        end else begin
          nxt_s.d_trip_cnt = adv(s_ff.d_trip_cnt, tick);
        end
      end
      if (meas.load > s_ff.cfg.dummy_lvl[31:16] && s_ff.dummy != '0) begin
        if (s_ff.d_ret_cnt >= s_ff.cfg.dummy_dly[31:16]) begin
          nxt_s.dummy = {1'b0, s_ff.dummy[gsq_pkg::MAX_STEPS-1:1]};
        end else begin
          nxt_s.d_ret_cnt = adv(s_ff.d_ret_cnt, tick);
        end
      end
    end
    if (nxt_s.seq != gsq_pkg::SEQ_ONLOAD) begin
      nxt_s.dummy = '0;
    end
    // load shedding stepping
    nxt_s.s_trip_cnt = 16'h0000;
    nxt_s.s_ret_cnt  = 16'h0000;
    if (on_load && s_ff.cfg.shed_en && nxt_s.seq == gsq_pkg::SEQ_ONLOAD) begin
      if (meas.load >= s_ff.cfg.shed_lvl[15:0]
          && s_ff.shed != step_mask(s_ff.cfg.shed_n)) begin
        if (s_ff.s_trip_cnt >= s_ff.cfg.shed_dly[15:0]) begin
          nxt_s.shed = {s_ff.shed[gsq_pkg::MAX_STEPS-2:0], 1'b1};
        end else begin
          nxt_s.s_trip_cnt = adv(s_ff.s_trip_cnt, tick);
        end
      end
      if (meas.load < s_ff.cfg.shed_lvl[31:16] && s_ff.shed != '0) begin
        if (s_ff.s_ret_cnt >= s_ff.cfg.shed_dly[31:16]) begin
          nxt_s.shed = {1'b0, s_ff.shed[gsq_pkg::MAX_STEPS-1:1]};
        end else begin
          nxt_s.s_ret_cnt = adv(s_ff.s_ret_cnt, tick);
        end
      end
    end
    // ecu override while held, then for the hold time
    if (nxt_s.auto_mode) begin
      nxt_s.ecu = 1'b0;
    end else if (p[gsq_pkg::P_START]) begin
      nxt_s.ecu     = 1'b1;
      nxt_s.ecu_cnt = 16'h0000;
    end else if (s_ff.ecu) begin
      nxt_s.ecu_cnt = adv(s_ff.ecu_cnt, tick);
      if (s_ff.ecu_cnt >= s_ff.cfg.stop_dly[31:16]) begin
        nxt_s.ecu = 1'b0;
      end
    end
    // low power after idle time in stop mode
    if (btn_rise != 4'h0 || nxt_s.auto_mode || !s_ff.cfg.lp_en) begin
      nxt_s.lp_cnt    = 20'h00000;
      nxt_s.low_power = 1'b0;
    end else if (s_ff.lp_cnt >= 20'(LP_TICKS)) begin
      nxt_s.low_power = 1'b1;
    end else begin
      nxt_s.lp_cnt = s_ff.lp_cnt + {19'h00000, tick};
    end
    // plant outputs follow the sequence
    nxt_s.fuel  = nxt_s.seq == gsq_pkg::SEQ_CRANK || nxt_s.seq == gsq_pkg::SEQ_PRELOAD
                  || nxt_s.seq == gsq_pkg::SEQ_ONLOAD;
    nxt_s.crank = nxt_s.seq == gsq_pkg::SEQ_CRANK;
    nxt_s.close = nxt_s.seq == gsq_pkg::SEQ_ONLOAD;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff                  <= '0;
      s_ff.seq              <= gsq_pkg::SEQ_IDLE;
      s_ff.cfg.stop_dly     <= {gsq_pkg::ECU_DLY_RST, gsq_pkg::FTS_DLY_RST};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs
  assign dummy_out    = s_ff.dummy;
  assign shed_out     = s_ff.shed;
  assign fuel_out     = s_ff.fuel;
  assign crank_out    = s_ff.crank;
  assign gen_close    = s_ff.close;
  assign ecu_power    = s_ff.ecu;
  assign low_power    = s_ff.low_power;
  assign fail_to_stop = s_ff.fts_alarm;
  assign alarm_reset  = s_ff.alarm_clr;
  assign cfg_unlocked = cfg_ok;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  shed_drop_a: assert property ($rose(s_ff.seq == gsq_pkg::SEQ_STOPPING)
    |-> s_ff.shed == '0 && !s_ff.close) else $error("shed outputs held at stop");
  stop_nostart_a: assert property (!s_ff.auto_mode && !auto_req
    |=> !s_ff.crank && s_ff.seq != gsq_pkg::SEQ_DELAY) else $error("start in stop mode");
  rest_def_a: assert property (s_ff.seq == gsq_pkg::SEQ_STOPPING ##1
    s_ff.seq == gsq_pkg::SEQ_IDLE |-> $past(meas.speed) == 16'h0000
    && $past(meas.freq) == 16'h0000 && (!PICKUP || $past(s_ff.sync2[gsq_pkg::P_OIL])))
    else $error("rest without zero speed");
  crank_due_a: assert property (s_ff.seq == gsq_pkg::SEQ_DELAY && any_req && start_due
    && !stop_req |=> s_ff.crank && s_ff.fuel) else $error("no crank at delay end");
  abandon_a: assert property (s_ff.seq == gsq_pkg::SEQ_DELAY && !any_req
    |=> s_ff.seq == gsq_pkg::SEQ_IDLE && !s_ff.fuel) else $error("start not abandoned");
  dummy_off_a: assert property (s_ff.seq != gsq_pkg::SEQ_ONLOAD
    |-> s_ff.dummy == '0) else $error("dummy load off load");
  preload_a: assert property (s_ff.seq == gsq_pkg::SEQ_PRELOAD && s_ff.cfg.shed_en
    |-> s_ff.shed == step_mask(s_ff.cfg.shed_start_n) && !s_ff.close)
    else $error("startup shed missing");
  lock_mode_a: assert property (p[gsq_pkg::P_LOCK]
    |=> $stable(s_ff.auto_mode)) else $error("mode changed under lock");
  alarm_clr_a: assert property ($fell(s_ff.auto_mode) |-> s_ff.alarm_clr)
    else $error("no alarm reset at stop entry");
  ecu_hold_a: assert property (!s_ff.auto_mode && p[gsq_pkg::P_START] && !auto_req
    |=> s_ff.ecu ##1 (s_ff.ecu || s_ff.auto_mode)) else $error("ecu not powered");

  crank_c: cover property (s_ff.seq == gsq_pkg::SEQ_DELAY ##1 s_ff.crank);
  dummy_full_c: cover property (s_ff.dummy == step_mask(s_ff.cfg.dummy_n) && s_ff.dummy != '0);
  fts_c: cover property ($rose(s_ff.fts_alarm));
endmodule // gsq_sequencer
`default_nettype wire

// ---- logic/gsq_pkg.sv ----
`default_nettype none
package gsq_pkg;
  // clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC_DFLT = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned LP_TIME_S     = 300;
  localparam int unsigned LP_TICKS_DFLT = LP_TIME_S * 1000000 / TICK_US;
  localparam int unsigned MAX_STEPS     = 5;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MODE      = 8'h04;
  localparam logic [7:0] OFS_DUMMY_LVL = 8'h08;
  localparam logic [7:0] OFS_SHED_LVL  = 8'h0c;
  localparam logic [7:0] OFS_DUMMY_DLY = 8'h10;
  localparam logic [7:0] OFS_SHED_DLY  = 8'h14;
  localparam logic [7:0] OFS_STOP_DLY  = 8'h18;
  localparam logic [7:0] OFS_START_A   = 8'h1c;
  localparam logic [7:0] OFS_START_B   = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;
  // synchronised pin positions
  localparam int unsigned NPIN    = 9;
  localparam int unsigned P_STOP  = 0;
  localparam int unsigned P_AUTO  = 1;
  localparam int unsigned P_START = 2;
  localparam int unsigned P_OTHER = 3;
  localparam int unsigned P_LOCK  = 4;
  localparam int unsigned P_OIL   = 5;
  localparam int unsigned P_AUX   = 6;
  localparam int unsigned P_LINK  = 7;
  localparam int unsigned P_BRK   = 8;
  // reset values of timing configuration, in ticks
  localparam logic [15:0] FTS_DLY_RST = 16'h2710;
  localparam logic [15:0] ECU_DLY_RST = 16'h0bb8;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b000,
    SEQ_DELAY   = 3'b001,
    SEQ_CRANK   = 3'b011,
    SEQ_PRELOAD = 3'b010,
    SEQ_ONLOAD  = 3'b110,
    SEQ_STOPPING = 3'b111
  } gsq_seq_e;

  typedef struct packed {
    logic [15:0] load;
    logic [15:0] speed;
    logic [15:0] freq;
  } gsq_meas_s;

  typedef struct packed {
    logic        dummy_en;
    logic        shed_en;
    logic        lp_en;
    logic [2:0]  dummy_n;
    logic [2:0]  shed_n;
    logic [2:0]  shed_start_n;
    logic [31:0] dummy_lvl;
    logic [31:0] shed_lvl;
    logic [31:0] dummy_dly;
    logic [31:0] shed_dly;
    logic [31:0] stop_dly;
    logic [31:0] start_a;
    logic [31:0] start_b;
  } gsq_cfg_s;

  typedef struct packed {
    gsq_cfg_s              cfg;
    logic [NPIN-1:0]       sync1;
    logic [NPIN-1:0]       sync2;
    logic [NPIN-1:0]       pin_q;
    logic [19:0]           pre;
    logic                  auto_mode;
    gsq_seq_e              seq;
    logic [MAX_STEPS-1:0]  dummy;
    logic [MAX_STEPS-1:0]  shed;
    logic [15:0]           d_trip_cnt;
    logic [15:0]           d_ret_cnt;
    logic [15:0]           s_trip_cnt;
    logic [15:0]           s_ret_cnt;
    logic [15:0]           start_cnt;
    logic [15:0]           stop_cnt;
    logic [15:0]           ecu_cnt;
    logic [19:0]           lp_cnt;
    logic                  fuel;
    logic                  crank;
    logic                  close;
    logic                  ecu;
    logic                  low_power;
    logic                  fts_alarm;
    logic                  alarm_clr;
    logic [31:0]           prdata;
  } gsq_state_s;
endpackage
`default_nettype wire

// ---- tb/gsq_plant_model.sv ----
`default_nettype none
module gsq_plant_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // commands from the controller, and the stuck fault from the test
  input  wire logic        fuel,
  input  wire logic        crank,
  input  wire logic        gen_close,
  input  wire logic        stuck,
  // engine and breaker feedback
  output var  logic [15:0] speed,
  output var  logic [15:0] freq,
  output var  logic        oil_closed,
  output var  logic        brk_closed
);
  timeunit 1ns;
  timeprecision 1ns;
  // engine fires on crank, runs on fuel, coasts down unless stuck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed      <= 16'h0000;
      brk_closed <= 1'b0;
    end else begin
      if (fuel && (crank || speed >= 16'h01f4)) begin
        speed <= (speed < 16'h05dc) ? speed + 16'h0064 : speed;
      end else if (!stuck) begin
        speed <= (speed >= 16'h0064) ? speed - 16'h0064 : 16'h0000;
      end
      brk_closed <= gen_close;  // breaker follows its command one cycle late
    end
  end
  // alternator frequency tracks speed, oil switch closed only at rest
  assign freq       = speed >> 5;
  assign oil_closed = (speed == 16'h0000);
endmodule // gsq_plant_model
`default_nettype wire

// ---- tb/genset_mode_load_sequencer_tb_top.sv ----
`default_nettype none
module genset_mode_load_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, stuck, sched, telem;
  logic [7:0]  paddr, btn;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, fuel, crank, gclose, ecu, lowp, fts, arst, cfgu;
  logic [4:0]  dmy, shd;
  logic [15:0] load, spd, frq;
  logic        oil, brk;
  wire logic [8:0] pins;
  gsq_pkg::gsq_meas_s meas;
  int          err_total, total_checks;
  assign pins = {brk, btn[7:6], oil, btn[4:0]};
  assign meas = {load, spd, frq};
  // device under test with a short tick and low-power time
  gsq_sequencer #(.TICK_CYCLES(2), .LP_TICKS(20)) i_gsq_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .sched_req(sched), .telem_req(telem), .pins(pins), .dummy_out(dmy),
    .shed_out(shd), .fuel_out(fuel), .crank_out(crank), .gen_close(gclose),
    .ecu_power(ecu), .low_power(lowp), .fail_to_stop(fts), .alarm_reset(arst),
    .cfg_unlocked(cfgu));
  // engine and breaker
  gsq_plant_model i_gsq_plant_model (
    .pclk(pclk), .presetn(presetn), .fuel(fuel), .crank(crank), .gen_close(gclose),
    .stuck(stuck), .speed(spd), .freq(frq), .oil_closed(oil), .brk_closed(brk));
  // 10 mhz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, result in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic press(input int i);
    btn[i] <= 1'b1; wt(6); btn[i] <= 1'b0; wt(6);
  endtask
  // reset state, unmapped and read-only accesses, configuration
  task automatic t_reset;
    chk({fuel, crank, gclose, dmy, shd}, 32'h0);
    chk(cfgu, 1'b1);
    apb(1'b0, 8'h30, 32'h0); chk(err, 1'b1); chk(rd, 32'h0);
    apb(1'b1, gsq_pkg::OFS_STATUS, 32'h1); chk(err, 1'b1);
    apb(1'b0, gsq_pkg::OFS_STOP_DLY, 32'h0);
    chk(rd, {gsq_pkg::ECU_DLY_RST, gsq_pkg::FTS_DLY_RST});
    apb(1'b1, gsq_pkg::OFS_CTRL, 32'h1223); chk(err, 1'b0);
    apb(1'b1, gsq_pkg::OFS_DUMMY_LVL, 32'h0190_0064);
    apb(1'b1, gsq_pkg::OFS_SHED_LVL, 32'h0258_0320);
    apb(1'b1, gsq_pkg::OFS_DUMMY_DLY, 32'h0005_0005);
    apb(1'b1, gsq_pkg::OFS_SHED_DLY, 32'h0005_0005);
    apb(1'b1, gsq_pkg::OFS_STOP_DLY, 32'h000a_0014);
    apb(1'b1, gsq_pkg::OFS_START_A, 32'h000a_000a);
    apb(1'b1, gsq_pkg::OFS_START_B, 32'h001e_000a);
    apb(1'b0, gsq_pkg::OFS_CTRL, 32'h0); chk(rd, 32'h0000_1223);
  endtask
  // start on remote input, load steps, stop on withdrawal
  task automatic t_run;
    btn[gsq_pkg::P_AUX] <= 1'b1;
    wt(30); chk(fuel, 1'b0);
    btn[gsq_pkg::P_LOCK] <= 1'b1;
    apb(1'b1, gsq_pkg::OFS_MODE, 32'h2); apb(1'b0, gsq_pkg::OFS_MODE, 32'h0);
    chk(rd[0], 1'b0);
    btn[gsq_pkg::P_LOCK] <= 1'b0;
    apb(1'b1, gsq_pkg::OFS_MODE, 32'h2);
    wt(10); chk(fuel, 1'b0);
    for (int i = 0; i < 80 && fuel !== 1'b1; i++) @(posedge pclk);
    chk({fuel, crank}, 2'b11);
    for (int i = 0; i < 80 && gclose !== 1'b1; i++) @(posedge pclk);
    chk({gclose, shd, dmy}, {1'b1, 5'h01, 5'h00});
    apb(1'b1, gsq_pkg::OFS_CTRL, 32'h1223); chk(err, 1'b1);
    chk(cfgu, 1'b0);
    load <= 16'd50;
    for (int i = 0; i < 80 && dmy === 5'h00; i++) @(posedge pclk);
    chk(dmy, 5'h01);
    wt(60); chk({dmy, shd}, {5'h03, 5'h00});
    load <= 16'd900;
    for (int i = 0; i < 80 && dmy === 5'h03; i++) @(posedge pclk);
    chk(dmy, 5'h01);
    wt(60); chk({dmy, shd}, {5'h00, 5'h03});
    btn[gsq_pkg::P_AUX] <= 1'b0;
    for (int i = 0; i < 80 && gclose !== 1'b0; i++) @(posedge pclk);
    chk({gclose, shd}, 6'h0);
    wt(40); chk(fuel, 1'b0);
  endtask
  // stop while running, engine refuses to stop, alarm and reset
  task automatic t_stop;
    sched <= 1'b1;
    for (int i = 0; i < 200 && gclose !== 1'b1; i++) @(posedge pclk);
    stuck <= 1'b1;
    btn[gsq_pkg::P_STOP] <= 1'b1;
    for (int i = 0; i < 20 && gclose !== 1'b0; i++) @(posedge pclk);
    chk({gclose, shd}, 6'h0);
    wt(3); chk({fuel, fts}, 2'b00);
    btn[gsq_pkg::P_STOP] <= 1'b0;
    wt(60); chk({fts, fuel}, 2'b10);
    sched <= 1'b0; stuck <= 1'b0;
    wt(40); press(gsq_pkg::P_AUTO);
    btn[gsq_pkg::P_STOP] <= 1'b1;
    for (int i = 0; i < 20 && arst !== 1'b1; i++) @(posedge pclk);
    chk(arst, 1'b1);
    wt(2); chk({arst, fts}, 2'b00);
    btn[gsq_pkg::P_STOP] <= 1'b0;
  endtask
  // request withdrawn during the start delay
  task automatic t_abort;
    press(gsq_pkg::P_AUTO);
    telem <= 1'b1; wt(40); chk(fuel, 1'b0);
    telem <= 1'b0; wt(6);
    apb(1'b0, gsq_pkg::OFS_STATUS, 32'h0); chk(rd[10:8], 32'h0);
    wt(100); chk(fuel, 1'b0);
    press(gsq_pkg::P_STOP);
  endtask
  // ecu held on start button, low power after idle time
  task automatic t_ecu_lp;
    apb(1'b1, gsq_pkg::OFS_CTRL, 32'h1227);
    btn[gsq_pkg::P_START] <= 1'b1;
    wt(30); chk({ecu, fuel, crank}, 3'b100);
    btn[gsq_pkg::P_START] <= 1'b0;
    wt(8); chk(ecu, 1'b1);
    chk(lowp, 1'b0);
    wt(30); chk(ecu, 1'b0);
    chk(lowp, 1'b1);
    press(gsq_pkg::P_OTHER); chk(lowp, 1'b0);
  endtask
  // stimulus
  initial begin
    {psel, penable, pwrite, stuck, sched, telem} = 6'h0;
    paddr = 8'h00; pwdata = 32'h0; btn = 8'h00; load = 16'd500;
    err_total = 0; total_checks = 0; presetn = 1'b0;
    wt(16); presetn <= 1'b1; wt(4);
    t_reset(); t_run(); t_stop(); t_abort(); t_ecu_lp();
    finish_test();
  end
  // watchdog
  initial begin
    wt(20000);
    err_total++;
    finish_test();
  end
endmodule // genset_mode_load_sequencer_tb_top
`default_nettype wire
